/* File: hw/tirc_params.svh */
/*
  Constants for the timer and port control register block: register
  indices, field positions, reset values and widths.
  Assumes it is included by bare name from the package and the design.
*/
`ifndef TIRC_PARAMS_SVH
`define TIRC_PARAMS_SVH
`define TIRC_ADDR_W 4
`define TIRC_REG_MAIN 4'h0
`define TIRC_REG_P5DIR 4'h1
`define TIRC_REG_P6DIR 4'h2
`define TIRC_REG_P7DIR 4'h3
`define TIRC_REG_CMPA 4'h4
`define TIRC_REG_BC 4'h5
`define TIRC_REG_IRC 4'h6
`define TIRC_REG_P5PD 4'h7
`define TIRC_REG_TMAIN 4'h8
`define TIRC_REG_TA 4'h9
`define TIRC_REG_TBL 4'hA
`define TIRC_REG_TBH 4'hB
`define TIRC_REG_TC 4'hC
`define TIRC_RST_ZERO 8'h00
`define TIRC_RST_ONES 8'hFF
`define TIRC_P7DIR_MASK 8'h01
`define TIRC_P5DIR_SMALL_MASK 8'h3F
`define TIRC_CMPA_RW_MASK 8'h1F
`define TIRC_BC_RW_MASK 8'hF7
`define TIRC_BIT_IRQ_EDGE 7
`define TIRC_BIT_GIE 6
`define TIRC_BIT_CMP_RES 5
`define TIRC_PIN_IR 7
`define TIRC_PS_MAX 8'hFF
`define TIRC_CNT_ONE 8'h01
`define TIRC_MAIN_COUNTS 256
`endif

/* File: hw/tirc_pkg.sv */
/*
  Types for the timer and port control register block.
  Assumes tirc_params.svh is on the include path.
*/
package tirc_pkg;
  `include "tirc_params.svh"
  // main timer and irq config layout
  typedef struct packed {
    logic irq_edge_sel;
    logic gie;
    logic main_timer_src_sel;
    logic main_timer_edge_sel;
    logic main_prescale_en;
    logic [2:0] main_prescale_ratio;
  } tirc_main_t;
  typedef struct packed {
    logic [1:0] unused;
    logic comparator_result;
    logic [1:0] comparator_func_sel;
    logic timer_a_enable;
    logic timer_a_src_sel;
    logic timer_a_edge_sel;
  } tirc_cmpa_t;
  typedef struct packed {
    logic timer_b_high_byte_en;
    logic timer_b_enable;
    logic timer_b_src_sel;
    logic timer_b_edge_sel;
    logic unused;
    logic timer_c_enable;
    logic timer_c_src_sel;
    logic timer_c_edge_sel;
  } tirc_bc_t;
  typedef struct packed {
    logic timer_c_scale_en;
    logic [2:0] timer_c_scale_ratio;
    logic infrared_modulator_enable;
    logic carrier_mode_sel;
    logic long_pulse_mode;
    logic infrared_pin_func_sel;
  } tirc_irc_t;
  // comparator function codes
  typedef enum logic [1:0] {
    TIRC_CMP_OFF = 2'b00,
    TIRC_CMP_ONLY = 2'b01,
    TIRC_CMP_PIN = 2'b10,
    TIRC_OPAMP_PIN = 2'b11
  } tirc_cmp_mode_t;
endpackage : tirc_pkg

/* File: hw/tirc_top.sv */
/*
  Timer and port control register block: config registers, main timer
  with prescaler, timers A/B/C, external interrupt edge detect, infrared
  pin selection and port direction/pull-down registers.
  Assumes pins are asynchronous and are synchronised here; the core
  supplies one-cycle instruction pulses and the comparator result.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tirc_params.svh"
module tirc_top
  import tirc_pkg::*;
#(
  parameter bit SMALL_PACKAGE = 1'b1,
  parameter int CLK_PER_INSTR = 2
)(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire logic instr_cycle,
  input wire logic irq_disable_instr,
  input wire logic irq_enable_instr,
  input wire logic return_from_irq_instr,
  input wire logic hw_irq_entry,
  input wire logic ext_irq_pin,
  input wire logic main_timer_count_pin,
  input wire logic timer_a_count_pin,
  input wire logic timer_b_count_pin,
  input wire logic timer_c_count_pin,
  input wire logic comparator_in,
  input wire logic carrier_low_seg,
  input wire logic pwm_wave,
  output logic ext_irq_event,
  output logic [7:0] port5_dir_oe_n,
  output logic [7:0] port6_dir_oe_n,
  output logic [7:0] port7_dir_oe_n,
  output logic [7:0] port5_pulldown_disable,
  output logic infrared_output_pin,
  output logic infrared_pin_oe,
  output logic [1:0] comparator_mode,
  output logic comparator_output_pin_en,
  output logic [7:0] main_timer_count,
  output logic [7:0] timer_a_count,
  output logic [15:0] timer_b_count,
  output logic [7:0] timer_c_count
);
  localparam logic [7:0] P5_MASK = SMALL_PACKAGE ? `TIRC_P5DIR_SMALL_MASK : `TIRC_RST_ONES;

  tirc_main_t main_cfg;
  tirc_cmpa_t cmpa_cfg;
  tirc_bc_t bc_cfg;
  tirc_irc_t irc_cfg;
  logic [7:0] p5dir, p6dir, p7dir, p5pd;
  logic [4:0] sync1, sync2, sync3;
  logic cmp_s1, cmp_s2;
  logic main_tick, ta_tick, tb_tick, tc_tick;
  logic [7:0] main_ps, tc_ps;
  logic [7:0] main_ps_lim, tc_ps_lim;
  logic [7:0] next_rdata;

  // two-flop synchronisers plus a third stage for edge detection
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
      sync3 <= 5'h00;
      cmp_s1 <= 1'b0;
      cmp_s2 <= 1'b0;
    end
    else
    begin
      sync1 <= {ext_irq_pin, main_timer_count_pin, timer_a_count_pin, timer_b_count_pin, timer_c_count_pin};
      sync2 <= sync1;
      sync3 <= sync2;
      cmp_s1 <= comparator_in;
      cmp_s2 <= cmp_s1;
    end
  end

  // edge picked by select: 0 rising, 1 falling
  function automatic logic pin_edge(input logic now, input logic prev, input logic fall);
    pin_edge = fall ? (prev & ~now) : (now & ~prev);
  endfunction : pin_edge

  // external interrupt edge detection
  always_ff @(posedge mclk)
  begin
    if (rst)
      ext_irq_event <= 1'b0;
    else
      ext_irq_event <= pin_edge(sync2[4], sync3[4], main_cfg.irq_edge_sel);
  end

  // source select per timer
  always_comb
  begin
    main_tick = main_cfg.main_timer_src_sel ? pin_edge(sync2[3], sync3[3], main_cfg.main_timer_edge_sel)
                                            : instr_cycle;
    ta_tick = cmpa_cfg.timer_a_enable &
              (cmpa_cfg.timer_a_src_sel ? pin_edge(sync2[2], sync3[2], cmpa_cfg.timer_a_edge_sel)
                                        : instr_cycle);
    tb_tick = bc_cfg.timer_b_enable &
              (bc_cfg.timer_b_src_sel ? pin_edge(sync2[1], sync3[1], bc_cfg.timer_b_edge_sel)
                                      : instr_cycle);
    // in carrier mode the scaler only sees low segments of the carrier
    tc_tick = bc_cfg.timer_c_enable &
              (bc_cfg.timer_c_src_sel ? pin_edge(sync2[0], sync3[0], bc_cfg.timer_c_edge_sel)
                                      : instr_cycle) &
              (~(irc_cfg.infrared_modulator_enable & irc_cfg.carrier_mode_sel) | carrier_low_seg);
    // divide ratio 2^(code+1), limit is ratio minus one
    main_ps_lim = 8'((16'h0002 << main_cfg.main_prescale_ratio) - 16'h0001);
    tc_ps_lim = 8'((16'h0002 << irc_cfg.timer_c_scale_ratio) - 16'h0001);
  end

  // main timer prescaler and 256-count counter; the instruction clock
  // already carries the 2- or 4-clock factor of the period
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      main_ps <= `TIRC_RST_ZERO;
      main_timer_count <= `TIRC_RST_ZERO;
    end
    else if (main_tick)
    begin
      if (!main_cfg.main_prescale_en || main_ps == main_ps_lim)
      begin
        main_ps <= `TIRC_RST_ZERO;
        main_timer_count <= main_timer_count + `TIRC_CNT_ONE;
      end
      else
        main_ps <= main_ps + `TIRC_CNT_ONE;
    end
  end

  // timer A
  always_ff @(posedge mclk)
  begin
    if (rst)
      timer_a_count <= `TIRC_RST_ZERO;
    else if (ta_tick)
      timer_a_count <= timer_a_count + `TIRC_CNT_ONE;
  end

  // timer B; the upper byte is held clear whenever not widened, so a
  // stale high byte never survives a switch back to 8-bit mode
  always_ff @(posedge mclk)
  begin
    if (rst)
      timer_b_count <= 16'h0000;
    else if (!bc_cfg.timer_b_high_byte_en)
      timer_b_count <= {8'h00, tb_tick ? timer_b_count[7:0] + `TIRC_CNT_ONE : timer_b_count[7:0]};
    else if (tb_tick)
      timer_b_count <= timer_b_count + 16'h0001;
  end

  // timer C scaler and counter
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      tc_ps <= `TIRC_RST_ZERO;
      timer_c_count <= `TIRC_RST_ZERO;
    end
    else if (tc_tick)
    begin
      if (!irc_cfg.timer_c_scale_en || tc_ps == tc_ps_lim)
      begin
        tc_ps <= `TIRC_RST_ZERO;
        timer_c_count <= timer_c_count + `TIRC_CNT_ONE;
      end
      else
        tc_ps <= tc_ps + `TIRC_CNT_ONE;
    end
  end

  // config registers; the enable flag and comparator result share this
  // process so each packed register has a single driver
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      main_cfg.gie <= 1'b0;
      cmpa_cfg.comparator_result <= 1'b0;
      {main_cfg.irq_edge_sel, main_cfg.main_timer_src_sel, main_cfg.main_timer_edge_sel,
       main_cfg.main_prescale_en, main_cfg.main_prescale_ratio} <= 7'h00;
      cmpa_cfg.unused <= 2'b00;
      {cmpa_cfg.comparator_func_sel, cmpa_cfg.timer_a_enable, cmpa_cfg.timer_a_src_sel,
       cmpa_cfg.timer_a_edge_sel} <= 5'h00;
      bc_cfg <= `TIRC_RST_ZERO;
      irc_cfg <= `TIRC_RST_ZERO;
      p5dir <= P5_MASK & `TIRC_RST_ONES;
      p6dir <= `TIRC_RST_ONES;
      p7dir <= `TIRC_P7DIR_MASK;
      p5pd <= `TIRC_RST_ONES;
    end
    else
    begin
      // enable flag: instructions and interrupt entry only; disable wins over enable
      if (irq_disable_instr || hw_irq_entry)
        main_cfg.gie <= 1'b0;
      else if (irq_enable_instr || return_from_irq_instr)
        main_cfg.gie <= 1'b1;
      cmpa_cfg.comparator_result <= cmp_s2;
      if (wr_en)
      begin
      case (addr)
        `TIRC_REG_MAIN:
        begin
          main_cfg.irq_edge_sel <= wdata[`TIRC_BIT_IRQ_EDGE];
          {main_cfg.main_timer_src_sel, main_cfg.main_timer_edge_sel,
           main_cfg.main_prescale_en, main_cfg.main_prescale_ratio} <= wdata[5:0];
        end
        `TIRC_REG_P5DIR: p5dir <= wdata & P5_MASK;
        `TIRC_REG_P6DIR: p6dir <= wdata;
        `TIRC_REG_P7DIR: p7dir <= wdata & `TIRC_P7DIR_MASK;
        `TIRC_REG_CMPA:
        begin
          {cmpa_cfg.comparator_func_sel, cmpa_cfg.timer_a_enable, cmpa_cfg.timer_a_src_sel,
           cmpa_cfg.timer_a_edge_sel} <= wdata[4:0];
        end
        `TIRC_REG_BC: bc_cfg <= wdata & `TIRC_BC_RW_MASK;
        `TIRC_REG_IRC: irc_cfg <= wdata;
        `TIRC_REG_P5PD: p5pd <= wdata;
        default: ;
      endcase
      end
    end
  end

  // read mux; unmapped reads return zero
  always_comb
  begin
    case (addr)
      `TIRC_REG_MAIN: next_rdata = main_cfg;
      `TIRC_REG_P5DIR: next_rdata = p5dir;
      `TIRC_REG_P6DIR: next_rdata = p6dir;
      `TIRC_REG_P7DIR: next_rdata = p7dir;
      `TIRC_REG_CMPA: next_rdata = cmpa_cfg & (`TIRC_CMPA_RW_MASK | (8'h01 << `TIRC_BIT_CMP_RES));
      `TIRC_REG_BC: next_rdata = bc_cfg;
      `TIRC_REG_IRC: next_rdata = irc_cfg;
      `TIRC_REG_P5PD: next_rdata = p5pd;
      `TIRC_REG_TMAIN: next_rdata = main_timer_count;
      `TIRC_REG_TA: next_rdata = timer_a_count;
      `TIRC_REG_TBL: next_rdata = timer_b_count[7:0];
      `TIRC_REG_TBH: next_rdata = timer_b_count[15:8];
      `TIRC_REG_TC: next_rdata = timer_c_count;
      default: next_rdata = `TIRC_RST_ZERO;
    endcase
  end

  // read data stands one cycle after the strobe only
  always_ff @(posedge mclk)
  begin
    if (rst || !rd_en)
      rdata <= `TIRC_RST_ZERO;
    else
      rdata <= next_rdata;
  end

  // registered pin-facing outputs
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      port5_dir_oe_n <= P5_MASK & `TIRC_RST_ONES;
      port6_dir_oe_n <= `TIRC_RST_ONES;
      port7_dir_oe_n <= `TIRC_P7DIR_MASK;
      port5_pulldown_disable <= `TIRC_RST_ONES;
      infrared_output_pin <= 1'b1;
      infrared_pin_oe <= 1'b0;
      comparator_mode <= 2'b00;
      comparator_output_pin_en <= 1'b0;
    end
    else
    begin
      port5_dir_oe_n <= p5dir;
      port6_dir_oe_n <= p6dir;
      port7_dir_oe_n <= p7dir;
      port5_pulldown_disable <= p5pd;
      comparator_mode <= cmpa_cfg.comparator_func_sel;
      comparator_output_pin_en <= cmpa_cfg.comparator_func_sel[1];
      // output enable is also gated here by the pin direction bit p6dir[7]
      infrared_pin_oe <= irc_cfg.infrared_pin_func_sel & irc_cfg.infrared_modulator_enable
                         & ~p6dir[`TIRC_PIN_IR];
      if (!irc_cfg.infrared_modulator_enable)
        infrared_output_pin <= 1'b1;
      else if (irc_cfg.carrier_mode_sel)
        infrared_output_pin <= ~carrier_low_seg;
      else
        infrared_output_pin <= pwm_wave | (irc_cfg.long_pulse_mode & 1'b0);
    end
  end
endmodule : tirc_top
`default_nettype wire

/* File: verif/tirc_top_checker.sv */
/*
  Checker for tirc_top: register to pin timing, read data framing,
  enable flag, counter holds. Assumes it is bound to tirc_top.
*/
`timescale 1ns/1ps
`default_nettype none
module tirc_top_checker
  import tirc_pkg::*;
#(
  parameter bit SMALL_PACKAGE = 1'b1
)(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rdata,
  input wire logic irq_disable_instr,
  input wire logic irq_enable_instr,
  input wire logic hw_irq_entry,
  input wire logic ext_irq_pin,
  input wire logic ext_irq_event,
  input wire logic [7:0] port5_dir_oe_n,
  input wire logic [7:0] port6_dir_oe_n,
  input wire logic infrared_output_pin,
  input wire logic infrared_pin_oe,
  input wire logic [1:0] comparator_mode,
  input wire logic comparator_output_pin_en,
  input wire logic [7:0] timer_a_count,
  input wire logic [15:0] timer_b_count
);
  // small package leaves the top two port5 bits unbuilt
  localparam logic [7:0] P5_MASK = SMALL_PACKAGE ? 8'h3F : 8'hFF;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // pins follow the register one cycle after it updates
  p5_dir_a: assert property (wr_en && addr == 4'h1 |-> ##2 port5_dir_oe_n == ($past(wdata, 2) & P5_MASK))
    else $error("port5 direction wrong");
  dir_read_a: assert property (rd_en && addr == 4'h2 |=> rdata == port6_dir_oe_n)
    else $error("port6 readback differs from pins");
  rd_idle_a: assert property (!rd_en |=> rdata == 8'h00)
    else $error("read data outside read slot");
  gie_clr_a: assert property ((irq_disable_instr || hw_irq_entry) ##1 (rd_en && addr == 4'h0) |=> !rdata[6])
    else $error("enable flag not cleared");
  gie_set_a: assert property (irq_enable_instr && !irq_disable_instr && !hw_irq_entry ##1 (rd_en && addr == 4'h0) |=> rdata[6])
    else $error("enable flag not set");
  cmp_mode_a: assert property (wr_en && addr == 4'h4 |-> ##2 comparator_mode == $past(wdata[4:3], 2) && comparator_output_pin_en == $past(wdata[4], 2))
    else $error("comparator mode wrong");
  ir_idle_a: assert property (wr_en && addr == 4'h6 && !wdata[3] |-> ##2 infrared_output_pin)
    else $error("infrared pin not high");
  ir_oe_a: assert property (infrared_pin_oe |-> !port6_dir_oe_n[7])
    else $error("infrared drive without output direction");
  // two sync flops plus the edge register
  irq_edge_a: assert property (ext_irq_event |-> $past(ext_irq_pin, 3) != $past(ext_irq_pin, 4))
    else $error("interrupt without pin edge");
  ta_hold_a: assert property (wr_en && addr == 4'h4 && !wdata[2] ##1 !wr_en [*5] |-> $stable(timer_a_count))
    else $error("timer a moved while disabled");
  tb_byte_a: assert property (wr_en && addr == 4'h5 && !wdata[7] ##1 !wr_en [*3] |-> timer_b_count[15:8] == 8'h00)
    else $error("timer b high byte in 8 bit mode");
  cover property (ext_irq_event);
  cover property (infrared_pin_oe);
  cover property (timer_b_count[8]);
endmodule : tirc_top_checker
bind tirc_top tirc_top_checker #(.SMALL_PACKAGE(SMALL_PACKAGE)) u_chk (.*);
`default_nettype wire

/* File: verif/test_tirc_top.sv */
/*
  Bench for tirc_top: register rows with pin edges, rates, flag, pins.
  Assumes tirc_pkg and tirc_top are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module test_tirc_top
  import tirc_pkg::*;
();
  typedef struct {
    logic [3:0] a;
    logic [7:0] d, rs, rb;
    int ci;
    bit fall, on;
  } tirc_row_t;
  // addr, data, before, after, pin (5 none), falling, counts
  tirc_row_t rows [20] = '{
    '{4'h0, 8'h20, 8'h00, 8'h20, 0, 0, 1}, '{4'h0, 8'h30, 8'h20, 8'h30, 0, 1, 1},
    '{4'h0, 8'h80, 8'h30, 8'h80, 4, 1, 1}, '{4'h0, 8'h00, 8'h80, 8'h00, 4, 0, 1},
    '{4'h0, 8'h40, 8'h00, 8'h00, 5, 0, 0}, '{4'h4, 8'h07, 8'h00, 8'h07, 1, 1, 1},
    '{4'h4, 8'h03, 8'h07, 8'h03, 1, 0, 0}, '{4'h4, 8'hE6, 8'h03, 8'h06, 1, 0, 1},
    '{4'h5, 8'h60, 8'h00, 8'h60, 2, 0, 1}, '{4'h5, 8'h70, 8'h60, 8'h70, 2, 1, 1},
    '{4'h5, 8'h20, 8'h70, 8'h20, 2, 0, 0}, '{4'h5, 8'h0F, 8'h20, 8'h07, 3, 1, 1},
    '{4'h5, 8'h06, 8'h07, 8'h06, 3, 0, 1}, '{4'h5, 8'h02, 8'h06, 8'h02, 3, 0, 0},
    '{4'h1, 8'hFF, 8'h3F, 8'h3F, 5, 0, 0}, '{4'h2, 8'hA5, 8'hFF, 8'hA5, 5, 0, 0},
    '{4'h3, 8'hFF, 8'h01, 8'h01, 5, 0, 0}, '{4'h7, 8'h3C, 8'hFF, 8'h3C, 5, 0, 0},
    '{4'h6, 8'h5A, 8'h00, 8'h5A, 5, 0, 0}, '{4'hD, 8'h77, 8'h00, 8'h00, 5, 0, 0}};
  // {hw entry, return, enable, disable, flag}
  logic [4:0] gt [5] = '{5'b00101, 5'b00010, 5'b01001, 5'b10000, 5'b00110};
  logic mclk;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic instr_cycle = 1'b0;
  logic [3:0] ins = 4'h0;
  logic [4:0] pin = 5'h00;
  logic comparator_in = 1'b0;
  logic carrier_low_seg = 1'b0;
  logic pwm_wave = 1'b0;
  logic [7:0] rdata, port5_dir_oe_n, port6_dir_oe_n, port7_dir_oe_n, port5_pulldown_disable, q;
  logic [7:0] main_timer_count, timer_a_count, timer_c_count;
  logic [15:0] timer_b_count, n, b [5];
  logic [15:0] ev_n = 16'h0000;
  logic ext_irq_event, infrared_output_pin, infrared_pin_oe, comparator_output_pin_en, s;
  logic [1:0] comparator_mode;
  tirc_row_t r;
  int err_total = 0;
  int num_checks = 0;
  tirc_top #(.SMALL_PACKAGE(1'b1), .CLK_PER_INSTR(2)) dut (
    .mclk, .rst, .addr, .wdata, .wr_en, .rd_en, .rdata, .instr_cycle,
    .irq_disable_instr(ins[0]), .irq_enable_instr(ins[1]), .return_from_irq_instr(ins[2]),
    .hw_irq_entry(ins[3]), .ext_irq_pin(pin[4]), .main_timer_count_pin(pin[0]),
    .timer_a_count_pin(pin[1]), .timer_b_count_pin(pin[2]), .timer_c_count_pin(pin[3]),
    .comparator_in, .carrier_low_seg, .pwm_wave, .ext_irq_event, .port5_dir_oe_n,
    .port6_dir_oe_n, .port7_dir_oe_n, .port5_pulldown_disable, .infrared_output_pin,
    .infrared_pin_oe, .comparator_mode, .comparator_output_pin_en, .main_timer_count,
    .timer_a_count, .timer_b_count, .timer_c_count);
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // interrupt events have no register, so count them here
  always @(posedge mclk)
    if (ext_irq_event === 1'b1)
      ev_n <= ev_n + 16'h0001;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string nm);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // strobes drop after one edge; the idle cycle keeps tasks apart
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
    @(posedge mclk);
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1 d = rdata;
    @(posedge mclk);
  endtask : rd
  task automatic ticks(input int k);
    repeat (k)
    begin
      instr_cycle <= 1'b1;
      @(posedge mclk);
      instr_cycle <= 1'b0;
      @(posedge mclk);
    end
    repeat (4) @(posedge mclk);
  endtask : ticks
  function automatic logic [15:0] cnt(input int i);
    case (i)
      0: return {8'h00, main_timer_count};
      1: return {8'h00, timer_a_count};
      2: return timer_b_count;
      3: return {8'h00, timer_c_count};
      default: return ev_n;
    endcase
  endfunction : cnt
  task automatic rst_chk();
    chk({port5_dir_oe_n, port6_dir_oe_n}, 16'h3FFF, "dir reset");
    chk({port7_dir_oe_n, port5_pulldown_disable}, 16'h01FF, "p7 pd reset");
    chk(16'({infrared_output_pin, infrared_pin_oe, timer_b_count[7:0]}), 16'h0200, "ir reset");
  endtask : rst_chk
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  initial
  begin
    repeat (20000) @(posedge mclk);
    err_total++;
    test_done();
  end
  initial
  begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rst_chk();
    foreach (rows[i])
    begin
      r = rows[i];
      rd(r.a, q);
      chk(16'(q), 16'(r.rs), "reg before");
      wr(r.a, r.d);
      rd(r.a, q);
      chk(16'(q), 16'(r.rb), "reg after");
      if (r.ci < 5)
      begin
        b[0] = cnt(r.ci);
        s = pin[r.ci];
        repeat (5)
        begin
          pin[r.ci] <= ~pin[r.ci];
          repeat (4) @(posedge mclk);
        end
        repeat (6) @(posedge mclk);
        n = r.fall ? (s ? 16'h0003 : 16'h0002) : (s ? 16'h0002 : 16'h0003);
        chk(cnt(r.ci) - b[0], r.on ? n : 16'h0000, "pin edges");
      end
    end
    $display("register rows done");
    foreach (gt[i])
    begin
      ins <= gt[i][4:1];
      @(posedge mclk);
      ins <= 4'h0;
      rd(4'h0, q);
      chk(16'(q[6]), 16'(gt[i][0]), "enable flag");
    end
    // rising ratios keep the divider phase inside the new period
    wr(4'h4, 8'h04);
    wr(4'h5, 8'h04);
    for (int c = 0; c < 8; c++)
    begin
      wr(4'h0, 8'h08 | 8'(c));
      wr(4'h6, 8'h80 | 8'(c << 4));
      for (int j = 0; j < 4; j++)
        b[j] = cnt(j);
      ticks(4 << c);
      chk(cnt(0) - b[0], 16'h0002, "main rate");
      chk(cnt(3) - b[3], 16'h0002, "c rate");
      chk((cnt(1) - b[1]) & 16'h00FF, 16'((4 << c) & 255), "a ticks");
    end
    for (int h = 0; h < 2; h++)
    begin
      wr(4'h5, h ? 8'hC0 : 8'h40);
      b[2] = cnt(2);
      ticks(300);
      chk((cnt(2) - b[2]) & (h ? 16'hFFFF : 16'h00FF), h ? 16'h012C : 16'h002C, "b width");
    end
    wr(4'h5, 8'h04);
    wr(4'h6, 8'h0D);
    for (int k = 0; k < 2; k++)
    begin
      carrier_low_seg <= k[0];
      b[3] = cnt(3);
      ticks(8);
      chk(cnt(3) - b[3], k ? 16'h0008 : 16'h0000, "carrier gate");
    end
    wr(4'h2, 8'h7F);
    wr(4'h6, 8'h09);
    for (int k = 0; k < 2; k++)
    begin
      pwm_wave <= k[0];
      repeat (3) @(posedge mclk);
      chk(16'({infrared_pin_oe, infrared_output_pin}), 16'(2 + k), "ir pwm");
    end
    wr(4'h6, 8'h00);
    repeat (2) @(posedge mclk);
    chk(16'({infrared_pin_oe, infrared_output_pin}), 16'h0001, "ir off");
    for (int k = 0; k < 4; k++)
    begin
      wr(4'h4, 8'(k << 3));
      repeat (2) @(posedge mclk);
      chk(16'({comparator_mode, comparator_output_pin_en}), 16'(k * 2 + k / 2), "cmp mode");
    end
    comparator_in <= 1'b1;
    repeat (4) @(posedge mclk);
    rd(4'h4, q);
    chk(16'(q), 16'h0038, "cmp result");
    $display("mode tests done");
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rst_chk();
    test_done();
  end
endmodule : test_tirc_top
`default_nettype wire
